// ==== hdl/jtag_instruction_boundary_scan.sv ====
// Purpose: Test access port with instruction, boundary and flash paths.
// Assumes: test_clock from the tester; tms and tdi change on its low phase.
// Notes: Pin muxing runs on clk_sys; scan logic runs on test_clock.
`timescale 1ns/1ns
`include "jtag_defs.svh"
module jtag_instruction_boundary_scan #(
	parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary value.
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic test_clock,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	input wire logic bus_receive_pin_in,
	output logic bus_receive_pin_out,
	output logic bus_receive_pin_oe,
	input wire logic bus_transmit_pin_in,
	output logic bus_transmit_pin_out,
	output logic bus_transmit_pin_oe,
	input wire logic crystal_input_pin,
	input wire jtag_pkg::port_pins_t port_pin_in,
	output jtag_pkg::port_pins_t port_pin_out,
	output jtag_pkg::port_pins_t port_pin_oe,
	output logic weak_pullup_en,
	input wire logic core_rst_oe,
	input wire logic core_rx_out,
	input wire logic core_rx_oe,
	input wire logic core_tx_out,
	input wire logic core_tx_oe,
	input wire logic core_pullup_en,
	input wire jtag_pkg::port_pins_t core_port_out,
	input wire jtag_pkg::port_pins_t core_port_oe,
	output logic core_rst_in,
	output logic core_rx_in,
	output logic core_tx_in,
	output logic core_crystal_in,
	output jtag_pkg::port_pins_t core_port_in,
	input wire logic [`SFB_WIDTH-1:0] special_function_bus_capture,
	output logic [`SFB_WIDTH-1:0] special_function_bus_update
);
	localparam int BW = `BS_WIDTH;
	localparam int NW = `NVM_WIDTH;
	localparam int DW = `NVM_DATA_WIDTH;

	jtag_pkg::tap_state_t state_reg, state_next;
	jtag_pkg::path_sel_t path_sel;
	logic trst_meta_reg, tck_rst;
	logic [`IR_WIDTH-1:0] ir_shift_reg, ir_shift_next;
	logic [`IR_WIDTH-1:0] test_instruction_select_reg;
	logic [`IR_WIDTH-1:0] test_instruction_select_next;
	logic [BW-1:0] bs_shift_reg, bs_shift_next;
	logic [BW-1:0] bs_update_reg, bs_update_next;
	logic [BW-1:0] cap_meta_reg, cap_sync_reg;
	logic [`ID_WIDTH-1:0] id_shift_reg, id_shift_next;
	logic byp_reg, byp_next;
	logic [NW-1:0] nvm_shift_reg, nvm_shift_next;
	logic [2:0][DW-1:0] nvm_store_reg, nvm_store_next;
	logic upd_tgl_reg, upd_tgl_next;
	logic extest_tck_reg, extest_tck_next;
	logic tdo_bit;
	logic [1:0] nvm_idx;

	// The tck domain releases reset only on its own edge, so no cell
	// leaves reset in a half-clocked state.
	always_ff @(posedge test_clock or posedge sys_rst) begin
		if (sys_rst) begin
			trst_meta_reg <= 1'b1;
			tck_rst <= 1'b1;
		end else begin
			trst_meta_reg <= 1'b0;
			tck_rst <= trst_meta_reg;
		end
	end

	// Standard state sequence, steered by tms alone.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			jtag_pkg::st_reset: state_next = tms ? jtag_pkg::st_reset
				: jtag_pkg::st_idle;
			jtag_pkg::st_idle: state_next = tms ? jtag_pkg::st_dr_select
				: jtag_pkg::st_idle;
			jtag_pkg::st_dr_select: state_next = tms
				? jtag_pkg::st_ir_select : jtag_pkg::st_dr_capture;
			jtag_pkg::st_dr_capture: state_next = tms
				? jtag_pkg::st_dr_exit1 : jtag_pkg::st_dr_shift;
			jtag_pkg::st_dr_shift: state_next = tms
				? jtag_pkg::st_dr_exit1 : jtag_pkg::st_dr_shift;
			jtag_pkg::st_dr_exit1: state_next = tms
				? jtag_pkg::st_dr_update : jtag_pkg::st_dr_pause;
			jtag_pkg::st_dr_pause: state_next = tms
				? jtag_pkg::st_dr_exit2 : jtag_pkg::st_dr_pause;
			jtag_pkg::st_dr_exit2: state_next = tms
				? jtag_pkg::st_dr_update : jtag_pkg::st_dr_shift;
			jtag_pkg::st_dr_update: state_next = tms
				? jtag_pkg::st_dr_select : jtag_pkg::st_idle;
			jtag_pkg::st_ir_select: state_next = tms
				? jtag_pkg::st_reset : jtag_pkg::st_ir_capture;
			jtag_pkg::st_ir_capture: state_next = tms
				? jtag_pkg::st_ir_exit1 : jtag_pkg::st_ir_shift;
			jtag_pkg::st_ir_shift: state_next = tms
				? jtag_pkg::st_ir_exit1 : jtag_pkg::st_ir_shift;
			jtag_pkg::st_ir_exit1: state_next = tms
				? jtag_pkg::st_ir_update : jtag_pkg::st_ir_pause;
			jtag_pkg::st_ir_pause: state_next = tms
				? jtag_pkg::st_ir_exit2 : jtag_pkg::st_ir_pause;
			jtag_pkg::st_ir_exit2: state_next = tms
				? jtag_pkg::st_ir_update : jtag_pkg::st_ir_shift;
			jtag_pkg::st_ir_update: state_next = tms
				? jtag_pkg::st_dr_select : jtag_pkg::st_idle;
		endcase
	end

	// Instruction decode; anything unlisted falls to bypass.
	always_comb begin
		nvm_idx = 2'd0;
		unique case (test_instruction_select_reg)
			`IR_EXTEST, `IR_SAMPLE: path_sel = jtag_pkg::sel_boundary;
			`IR_IDCODE: path_sel = jtag_pkg::sel_ident;
			`IR_BYPASS: path_sel = jtag_pkg::sel_bypass;
			`IR_NVM_CTL: path_sel = jtag_pkg::sel_nvm_ctl;
			`IR_NVM_DAT: begin
				path_sel = jtag_pkg::sel_nvm_dat;
				nvm_idx = 2'd1;
			end
			`IR_NVM_ADR: begin
				path_sel = jtag_pkg::sel_nvm_adr;
				nvm_idx = 2'd2;
			end
			default: path_sel = jtag_pkg::sel_bypass;
		endcase
	end

	// Next values of all scan paths; each path moves only when chosen.
	always_comb begin
		ir_shift_next = ir_shift_reg;
		test_instruction_select_next = test_instruction_select_reg;
		bs_shift_next = bs_shift_reg;
		bs_update_next = bs_update_reg;
		id_shift_next = id_shift_reg;
		byp_next = byp_reg;
		nvm_shift_next = nvm_shift_reg;
		nvm_store_next = nvm_store_reg;
		upd_tgl_next = upd_tgl_reg;
		unique case (state_reg)
			jtag_pkg::st_reset:
				test_instruction_select_next = `IR_RESET;
			jtag_pkg::st_ir_capture: ir_shift_next = `IR_CAPTURE;
			jtag_pkg::st_ir_shift:
				ir_shift_next = {tdi, ir_shift_reg[`IR_WIDTH-1:1]};
			jtag_pkg::st_ir_update:
				test_instruction_select_next = ir_shift_reg;
			jtag_pkg::st_dr_capture: begin
				unique case (path_sel)
					jtag_pkg::sel_boundary: bs_shift_next = cap_sync_reg;
					jtag_pkg::sel_ident: id_shift_next = ID_VALUE;
					jtag_pkg::sel_bypass: byp_next = 1'b0;
					default: nvm_shift_next = {1'b0,
						nvm_store_reg[nvm_idx], 1'b0};
				endcase
			end
			jtag_pkg::st_dr_shift: begin
				unique case (path_sel)
					jtag_pkg::sel_boundary:
						bs_shift_next = {tdi, bs_shift_reg[BW-1:1]};
					jtag_pkg::sel_ident:
						id_shift_next = {tdi, id_shift_reg[`ID_WIDTH-1:1]};
					jtag_pkg::sel_bypass: byp_next = tdi;
					default: nvm_shift_next = {tdi, nvm_shift_reg[NW-1:1]};
				endcase
			end
			jtag_pkg::st_dr_update: begin
				if (path_sel == jtag_pkg::sel_boundary) begin
					bs_update_next = bs_shift_reg;
					upd_tgl_next = ~upd_tgl_reg;
				end else if (path_sel != jtag_pkg::sel_ident &&
					path_sel != jtag_pkg::sel_bypass &&
					nvm_shift_reg[NW-1:NW-2] == 2'b11) begin
					nvm_store_next[nvm_idx] = nvm_shift_reg[NW-3:0];
				end
			end
			default: begin
			end
		endcase
		// The mode flag follows the instruction as it is loaded, because the
		// tester may stop the test clock right after the update edge.
		extest_tck_next = (test_instruction_select_next == `IR_EXTEST);
	end

	// Registers of the tck domain.
	always_ff @(posedge test_clock or posedge tck_rst) begin
		if (tck_rst) begin
			state_reg <= jtag_pkg::st_reset;
			ir_shift_reg <= `IR_RESET;
			test_instruction_select_reg <= `IR_RESET;
			bs_shift_reg <= '0;
			bs_update_reg <= '0;
			id_shift_reg <= '0;
			byp_reg <= 1'b0;
			nvm_shift_reg <= '0;
			nvm_store_reg <= '0;
			upd_tgl_reg <= 1'b0;
			extest_tck_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ir_shift_reg <= ir_shift_next;
			test_instruction_select_reg <= test_instruction_select_next;
			bs_shift_reg <= bs_shift_next;
			bs_update_reg <= bs_update_next;
			id_shift_reg <= id_shift_next;
			byp_reg <= byp_next;
			nvm_shift_reg <= nvm_shift_next;
			nvm_store_reg <= nvm_store_next;
			upd_tgl_reg <= upd_tgl_next;
			extest_tck_reg <= extest_tck_next;
		end
	end

	// Capture values cross from clk_sys; pins are quasi-static during
	// capture, so a plain two-stage sample is adequate here.
	logic [BW-1:0] cap_src_reg, cap_src_next;
	always_ff @(posedge test_clock or posedge tck_rst) begin
		if (tck_rst) begin
			cap_meta_reg <= '0;
			cap_sync_reg <= '0;
		end else begin
			cap_meta_reg <= cap_src_reg;
			cap_sync_reg <= cap_meta_reg;
		end
	end

	// Serial output mux, launched on the falling edge as the standard
	// asks, so the tester samples it safely on the next rising edge.
	always_comb begin
		tdo_bit = byp_reg;
		if (state_reg == jtag_pkg::st_ir_shift) begin
			tdo_bit = ir_shift_reg[0];
		end else begin
			unique case (path_sel)
				jtag_pkg::sel_boundary: tdo_bit = bs_shift_reg[0];
				jtag_pkg::sel_ident: tdo_bit = id_shift_reg[0];
				jtag_pkg::sel_bypass: tdo_bit = byp_reg;
				default: tdo_bit = nvm_shift_reg[0];
			endcase
		end
	end
	always_ff @(negedge test_clock or posedge tck_rst) begin
		if (tck_rst) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= tdo_bit;
			tdo_oe <= (state_reg == jtag_pkg::st_ir_shift) ||
				(state_reg == jtag_pkg::st_dr_shift);
		end
	end

	// clk_sys side: pin synchronisers and mode and update crossings.
	logic rst_m, rst_s, rx_m, rx_s, tx_m, tx_s, xt_m, xt_s;
	jtag_pkg::port_pins_t port_m, port_s;
	logic ext_m, ext_s, tgl_m, tgl_s, tgl_d;
	logic [BW-1:0] bs_hold_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			{rst_m, rst_s, rx_m, rx_s, tx_m, tx_s, xt_m, xt_s} <= '0;
			port_m <= '0;
			port_s <= '0;
			{ext_m, ext_s, tgl_m, tgl_s, tgl_d} <= '0;
		end else begin
			{rst_m, rx_m, tx_m, xt_m} <= {rst_pin_in,
				bus_receive_pin_in, bus_transmit_pin_in,
				crystal_input_pin};
			{rst_s, rx_s, tx_s, xt_s} <= {rst_m, rx_m, tx_m, xt_m};
			port_m <= port_pin_in;
			port_s <= port_m;
			ext_m <= extest_tck_reg;
			ext_s <= ext_m;
			tgl_m <= upd_tgl_reg;
			tgl_s <= tgl_m;
			tgl_d <= tgl_s;
		end
	end

	// Boundary capture word built from synced pins and core controls.
	always_comb begin
		logic [31:0] pin_v;
		logic [31:0] oe_v;
		pin_v = port_s;
		oe_v = core_port_oe;
		cap_src_next = '0;
		cap_src_next[`CELL_RST_OE_A] = core_rst_oe;
		cap_src_next[`CELL_RST_OE_B] = core_rst_oe;
		cap_src_next[`CELL_RST_IO_A] = rst_s;
		cap_src_next[`CELL_RST_IO_B] = rst_s;
		cap_src_next[`CELL_RX_OE] = core_rx_oe;
		cap_src_next[`CELL_RX_IO] = rx_s;
		cap_src_next[`CELL_TX_OE] = core_tx_oe;
		cap_src_next[`CELL_TX_IO] = tx_s;
		cap_src_next[`CELL_XTAL] = xt_s;
		cap_src_next[`CELL_PULLUP] = core_pullup_en;
		for (int i = 0; i < 32; i++) begin
			cap_src_next[`CELL_PORT_BASE + 2*i] = oe_v[i];
			cap_src_next[`CELL_PORT_BASE + 2*i + 1] = pin_v[i];
		end
		cap_src_next[BW-1:`CELL_SFB_BASE] =
			special_function_bus_capture;
	end

	// Pin and core-input drive; the update word is copied only after the
	// toggle has settled, so every bit of it is already stable.
	logic [31:0] upd_oe, upd_out;
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			upd_oe[i] = bs_hold_reg[`CELL_PORT_BASE + 2*i];
			upd_out[i] = bs_hold_reg[`CELL_PORT_BASE + 2*i + 1];
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cap_src_reg <= '0;
			bs_hold_reg <= '0;
			rst_pin_out <= 1'b0;
			rst_pin_oe <= 1'b0;
			bus_receive_pin_out <= 1'b0;
			bus_receive_pin_oe <= 1'b0;
			bus_transmit_pin_out <= 1'b0;
			bus_transmit_pin_oe <= 1'b0;
			port_pin_out <= '0;
			port_pin_oe <= '0;
			weak_pullup_en <= 1'b0;
			core_rst_in <= 1'b1;
			core_rx_in <= 1'b1;
			core_tx_in <= 1'b1;
			core_crystal_in <= 1'b0;
			core_port_in <= '1;
			special_function_bus_update <= '0;
		end else begin
			cap_src_reg <= cap_src_next;
			if (tgl_s != tgl_d) begin
				bs_hold_reg <= bs_update_reg;
			end
			core_crystal_in <= xt_s;
			if (ext_s) begin
				rst_pin_oe <= bs_hold_reg[`CELL_RST_OE_A] |
					bs_hold_reg[`CELL_RST_OE_B];
				rst_pin_out <= bs_hold_reg[`CELL_RST_IO_A] &
					bs_hold_reg[`CELL_RST_IO_B];
				bus_receive_pin_oe <= bs_hold_reg[`CELL_RX_OE];
				bus_receive_pin_out <= bs_hold_reg[`CELL_RX_IO];
				bus_transmit_pin_oe <= bs_hold_reg[`CELL_TX_OE];
				bus_transmit_pin_out <= bs_hold_reg[`CELL_TX_IO];
				weak_pullup_en <= bs_hold_reg[`CELL_PULLUP];
				port_pin_oe <= upd_oe;
				port_pin_out <= upd_out;
				special_function_bus_update <=
					bs_hold_reg[BW-1:`CELL_SFB_BASE];
				core_rst_in <= 1'b1;
				core_rx_in <= 1'b1;
				core_tx_in <= 1'b1;
				core_port_in <= '1;
			end else begin
				rst_pin_oe <= core_rst_oe;
				rst_pin_out <= 1'b0;
				bus_receive_pin_oe <= core_rx_oe;
				bus_receive_pin_out <= core_rx_out;
				bus_transmit_pin_oe <= core_tx_oe;
				bus_transmit_pin_out <= core_tx_out;
				weak_pullup_en <= core_pullup_en;
				port_pin_oe <= core_port_oe;
				port_pin_out <= core_port_out;
				special_function_bus_update <= '0;
				core_rst_in <= rst_s;
				core_rx_in <= rx_s;
				core_tx_in <= tx_s;
				core_port_in <= port_s;
			end
		end
	end

	// Checks on the tck domain.
	tlr_five_ones_a: assert property (@(posedge test_clock)
		disable iff (tck_rst) tms [*5] |=> state_reg == jtag_pkg::st_reset)
		else $error("five tms ones did not reach reset state");
	ir_reset_zero_a: assert property (@(posedge test_clock)
		disable iff (tck_rst) state_reg == jtag_pkg::st_reset |=>
		test_instruction_select_reg == 16'h0000)
		else $error("instruction not zero after reset state");
	ir_update_load_a: assert property (@(posedge test_clock)
		disable iff (tck_rst) state_reg == jtag_pkg::st_ir_update |=>
		test_instruction_select_reg == $past(ir_shift_reg))
		else $error("instruction update did not load");
	unlisted_bypass_a: assert property (@(posedge test_clock)
		disable iff (tck_rst) !(test_instruction_select_reg inside
		{16'h0000, 16'h0002, 16'h0004, 16'h0082, 16'h0083,
		16'h0084}) |-> path_sel == jtag_pkg::sel_bypass)
		else $error("unlisted code not in bypass");
	bs_capture_word_a: assert property (@(posedge test_clock)
		disable iff (tck_rst) state_reg == jtag_pkg::st_dr_capture &&
		path_sel == jtag_pkg::sel_boundary |=>
		bs_shift_reg == $past(cap_sync_reg))
		else $error("boundary capture wrong");
	shift_holds_update_a: assert property (@(posedge test_clock)
		disable iff (tck_rst) state_reg == jtag_pkg::st_dr_shift |=>
		$stable(bs_update_reg))
		else $error("update stage moved during shift");
	// Checks on the clk_sys domain, then covers on the tck domain.
	sample_core_drive_a: assert property (@(posedge clk_sys)
		disable iff (sys_rst) !ext_s |=>
		port_pin_out == $past(core_port_out) &&
		port_pin_oe == $past(core_port_oe))
		else $error("pins not driven by core outside extest");
	extest_force_one_a: assert property (@(posedge clk_sys)
		disable iff (sys_rst) ext_s |=> core_port_in == 32'hFFFF_FFFF &&
		core_rx_in && core_tx_in && core_rst_in)
		else $error("core inputs not forced high in extest");
	extest_pin_drive_a: assert property (@(posedge clk_sys)
		disable iff (sys_rst) ext_s |=> weak_pullup_en ==
		$past(bs_hold_reg[9]))
		else $error("pullup not driven from update stage");
	cover_extest_load_c: cover property (@(posedge test_clock)
		state_reg == jtag_pkg::st_ir_update && ir_shift_reg == 16'h0000);
	cover_bypass_shift_c: cover property (@(posedge test_clock)
		state_reg == jtag_pkg::st_dr_shift &&
		path_sel == jtag_pkg::sel_bypass);
	cover_nvm_write_c: cover property (@(posedge test_clock)
		state_reg == jtag_pkg::st_dr_update &&
		path_sel == jtag_pkg::sel_nvm_dat &&
		nvm_shift_reg[19:18] == 2'b11);
endmodule

// ==== hdl/jtag_defs.svh ====
// Purpose: Constants of the test access port and boundary register.
// Assumes: Included by its bare name.
// Notes: Cell positions count from the serial output end.
`ifndef JTAG_DEFS_SVH
`define JTAG_DEFS_SVH
`define IR_WIDTH 16
`define IR_RESET 16'h0000
`define IR_CAPTURE 16'h0001
`define IR_EXTEST 16'h0000
`define IR_SAMPLE 16'h0002
`define IR_IDCODE 16'h0004
`define IR_BYPASS 16'hFFFF
`define IR_NVM_CTL 16'h0082
`define IR_NVM_DAT 16'h0083
`define IR_NVM_ADR 16'h0084
`define BS_WIDTH 134
`define ID_WIDTH 32
`define NVM_WIDTH 20
`define NVM_DATA_WIDTH 18
`define CELL_RST_OE_A 0
`define CELL_RST_IO_A 1
`define CELL_RST_OE_B 2
`define CELL_RST_IO_B 3
`define CELL_RX_OE 4
`define CELL_RX_IO 5
`define CELL_TX_OE 6
`define CELL_TX_IO 7
`define CELL_XTAL 8
`define CELL_PULLUP 9
`define CELL_PORT_BASE 10
`define CELL_SFB_BASE 74
`define SFB_WIDTH 60
`endif

// ==== hdl/jtag_pkg.sv ====
// Purpose: Types shared by the test access port design.
// Assumes: Nothing beyond the constants header.
// Notes: Port pins travel as one struct per direction.
package jtag_pkg;
	typedef enum logic [3:0] {
		st_reset, st_idle, st_dr_select, st_dr_capture, st_dr_shift,
		st_dr_exit1, st_dr_pause, st_dr_exit2, st_dr_update,
		st_ir_select, st_ir_capture, st_ir_shift, st_ir_exit1,
		st_ir_pause, st_ir_exit2, st_ir_update
	} tap_state_t;
	typedef enum logic [2:0] {
		sel_boundary, sel_ident, sel_bypass,
		sel_nvm_ctl, sel_nvm_dat, sel_nvm_adr
	} path_sel_t;
	typedef struct packed {
		logic [7:0] port_three_pin;
		logic [7:0] port_two_pin;
		logic [7:0] port_one_pin;
		logic [7:0] port_zero_pin;
	} port_pins_t;
endpackage

// ==== testbench/tap_tester.sv ====
// Purpose: Model of the external tester that drives three test pins and samples tdo.
// Assumes: The test clock runs only inside frames, 125 ns per period.
// Notes: Bits go out least significant first; tdo is taken on the rise.
`timescale 1ns/1ns
module tap_tester (
	output logic test_clock,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	logic seen;

	// The clock stands low between frames.
	initial begin
		test_clock = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		seen = 1'b0;
	end

	// One period; mode and data change only while the clock is low.
	task automatic pulse(input logic m, input logic d);
		tms = m;
		tdi = d;
		#31 test_clock = 1'b1;
		seen = tdo;
		#62 test_clock = 1'b0;
		tdi = ~d; // A released data line must not keep the old value.
		#32;
	endtask

	// Five cycles with mode select high reach reset from any state.
	task automatic tap_reset();
		repeat (5) pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b0);
	endtask

	// One frame from idle back to idle; ir chooses the instruction path.
	task automatic scan(input logic ir, input int len,
		input logic [133:0] din, output logic [133:0] dout);
		dout = '0;
		pulse(1'b1, 1'b0);
		if (ir) begin
			pulse(1'b1, 1'b0);
		end
		pulse(1'b0, 1'b0);
		pulse(1'b0, 1'b0);
		for (int i = 0; i < len; i++) begin
			pulse(i == len - 1, din[i]);
			dout[i] = seen;
		end
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b0);
	endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the test port and boundary register.
// Assumes: Frames come from the tester model, pin levels from here.
// Notes: Pins settle long before a frame ends, so short waits suffice.
`timescale 1ns/1ns
`include "jtag_defs.svh"
module tb_top;
	localparam logic [31:0] ID = 32'h0000_0051; // Arbitrary value.
	localparam logic [31:0] PA = 32'h5A3C_96E1;
	localparam logic [31:0] PB = 32'hA5C3_691E;
	localparam logic [133:0] CA = {{33{4'h9}}, 2'b10};
	logic clk_sys;
	logic sys_rst = 1'b1;
	logic test_clock, tms, tdi, tdo;
	logic rst_pin_in = 1'b0, rst_pin_out, rst_pin_oe;
	logic bus_receive_pin_in = 1'b0, bus_receive_pin_out, bus_receive_pin_oe;
	logic bus_transmit_pin_in = 1'b0, bus_transmit_pin_out;
	logic bus_transmit_pin_oe, weak_pullup_en, crystal_input_pin = 1'b0;
	logic core_rst_oe = 1'b0, core_rx_out = 1'b0, core_rx_oe = 1'b0;
	logic core_tx_out = 1'b0, core_tx_oe = 1'b0, core_pullup_en = 1'b0;
	logic core_rst_in, core_rx_in, core_tx_in, core_crystal_in, tdo_oe;
	jtag_pkg::port_pins_t port_pin_in = '0, core_port_out = '0;
	jtag_pkg::port_pins_t core_port_oe = '0;
	jtag_pkg::port_pins_t port_pin_out, port_pin_oe, core_port_in;
	logic [`SFB_WIDTH-1:0] special_function_bus_capture = '0;
	logic [`SFB_WIDTH-1:0] special_function_bus_update;
	logic [133:0] o;
	logic [17:0] d;
	int n_mismatch = 0;
	int compares = 0;

	tap_tester i_tester (
		.test_clock(test_clock), .tms(tms), .tdi(tdi), .tdo(tdo)
	);

	jtag_instruction_boundary_scan #(.ID_VALUE(ID)) i_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .test_clock(test_clock),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
		.rst_pin_oe(rst_pin_oe), .bus_receive_pin_in(bus_receive_pin_in),
		.bus_receive_pin_out(bus_receive_pin_out),
		.bus_receive_pin_oe(bus_receive_pin_oe),
		.bus_transmit_pin_in(bus_transmit_pin_in),
		.bus_transmit_pin_out(bus_transmit_pin_out),
		.bus_transmit_pin_oe(bus_transmit_pin_oe),
		.crystal_input_pin(crystal_input_pin), .port_pin_in(port_pin_in),
		.port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
		.weak_pullup_en(weak_pullup_en), .core_rst_oe(core_rst_oe),
		.core_rx_out(core_rx_out), .core_rx_oe(core_rx_oe),
		.core_tx_out(core_tx_out), .core_tx_oe(core_tx_oe),
		.core_pullup_en(core_pullup_en), .core_port_out(core_port_out),
		.core_port_oe(core_port_oe), .core_rst_in(core_rst_in),
		.core_rx_in(core_rx_in), .core_tx_in(core_tx_in),
		.core_crystal_in(core_crystal_in), .core_port_in(core_port_in),
		.special_function_bus_capture(special_function_bus_capture),
		.special_function_bus_update(special_function_bus_update)
	);

	// System clock of 8 ns.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Compares one value and counts the outcome.
	task automatic chk(input logic [133:0] seen, input logic [133:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Drives every pin and core input from one pattern, then lets it sync.
	task automatic drive(input logic [31:0] p);
		@(posedge clk_sys);
		port_pin_in <= p;
		core_port_out <= ~p;
		core_port_oe <= {p[7:0], p[31:8]};
		{bus_transmit_pin_in, bus_receive_pin_in, rst_pin_in} <= p[2:0];
		{core_rx_oe, core_rx_out, core_rst_oe, crystal_input_pin} <= p[6:3];
		{core_pullup_en, core_tx_oe, core_tx_out} <= p[9:7];
		special_function_bus_capture <= {p[27:0], p};
		repeat (8) @(posedge clk_sys);
	endtask

	// Data and instruction frames.
	task automatic dr(input int len, input logic [133:0] din);
		i_tester.scan(1'b0, len, din, o);
	endtask

	task automatic load(input logic [15:0] code);
		i_tester.scan(1'b1, 16, code, o);
		chk(o[15:0], `IR_CAPTURE);
		chk(tdo_oe, 1'b0);
	endtask

	// Captured cells must match the pattern that drove the inputs.
	task automatic chk_cap(input logic [31:0] p);
		logic [31:0] oe;
		oe = {p[7:0], p[31:8]};
		chk(o[3:0], {p[0], p[4], p[0], p[4]});
		chk(o[9:4], {p[9], p[3], p[2], p[8], p[1], p[6]});
		chk(o[133:74], {p[27:0], p});
		for (int k = 0; k < 32; k++) begin
			chk({o[10 + 2 * k], o[11 + 2 * k]}, {oe[k], p[k]});
		end
	endtask

	// In external test the pins show the update stage, the core sees ones except at its crystal input.
	task automatic chk_pins(input logic [133:0] c);
		chk({rst_pin_oe, rst_pin_out}, {c[0] | c[2], c[1] & c[3]});
		chk({bus_receive_pin_oe, bus_receive_pin_out}, {c[4], c[5]});
		chk({bus_transmit_pin_oe, bus_transmit_pin_out}, {c[6], c[7]});
		chk(weak_pullup_en, c[9]);
		chk(special_function_bus_update, c[133:74]);
		for (int k = 0; k < 32; k++) begin
			chk({port_pin_oe[k], port_pin_out[k]}, {c[10 + 2 * k], c[11 + 2 * k]});
		end
		chk({core_rst_in, core_rx_in, core_tx_in, core_port_in},
			35'h7_FFFF_FFFF);
	endtask

	// Cuts a hang short.
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_mismatch++;
		conclude();
	end

	// Main sequence; reset is held while the tester gives one test edge.
	initial begin
		fork
			i_tester.pulse(1'b1, 1'b0);
			begin
				repeat (8) @(posedge clk_sys);
				sys_rst <= 1'b0;
			end
		join
		drive(PA);
		i_tester.tap_reset();
		dr(134, CA);
		chk_cap(PA);
		repeat (4) @(posedge clk_sys);
		chk_pins(CA);
		// Sample mode captures and preloads the update stage; pins go back to the core.
		drive(PB);
		load(`IR_SAMPLE);
		dr(134, ~CA);
		chk_cap(PB);
		repeat (4) @(posedge clk_sys);
		chk({rst_pin_oe, rst_pin_out, bus_receive_pin_oe}, {PB[4], 1'b0, PB[6]});
		chk({bus_receive_pin_out, bus_transmit_pin_oe}, {PB[5], PB[8]});
		chk({bus_transmit_pin_out, weak_pullup_en}, {PB[7], PB[9]});
		chk({port_pin_oe, port_pin_out}, {PB[7:0], PB[31:8], ~PB});
		chk({core_port_in, special_function_bus_update}, {PB, 60'h0});
		chk({core_crystal_in, core_tx_in, core_rx_in, core_rst_in},
			PB[3:0]);
		// The preloaded word reaches the pins once external test returns.
		load(`IR_EXTEST);
		repeat (4) @(posedge clk_sys);
		chk_pins(~CA);
		load(`IR_IDCODE);
		dr(33, 134'h1);
		chk(o[32:0], {1'b1, ID});
		// Bypass and unlisted codes give one cell that captures zero.
		for (int j = 0; j < 3; j++) begin
			load(j == 0 ? `IR_BYPASS : (j == 1 ? 16'h1234 : 16'h0001));
			dr(2, 134'h1);
			chk(o[1:0], 2'b10);
		end
		// Flash paths store only on a write code and read back shifted up one bit.
		for (int j = 0; j < 3; j++) begin
			load(`IR_NVM_CTL + 16'(j));
			d = 18'h2_5A50 + 18'(j);
			dr(20, {2'b11, d});
			dr(20, {2'b00, ~d});
			chk(o[19:0], {1'b0, d, 1'b0});
			dr(20, 134'h0);
			chk(o[19:0], {1'b0, d, 1'b0});
		end
		load(`IR_NVM_CTL);
		dr(20, 134'h0);
		chk(o[19:0], {1'b0, 18'h2_5A50, 1'b0});
		conclude();
	end
endmodule
